// ===== mcg_axil_slave.sv
// axi4-lite slave front end turning bus beats into register strobes
`default_nettype none

module mcg_axil_slave #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address channel
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // write data channel
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // write response channel
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read address channel
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // read data channel
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // register side
    output logic wr_en,
    output logic [mcg_pkg::IDX_W-1:0] wr_idx,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_err,
    output logic rd_en,
    output logic [mcg_pkg::IDX_W-1:0] rd_idx,
    input wire logic [31:0] rd_data,
    input wire logic rd_err
);

    if (ADDR_W < 8) begin : g_addr_check
        $error("mcg_axil_slave: ADDR_W must be at least 8");
    end

    logic aw_full_reg;
    logic w_full_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic aw_full_next;
    logic w_full_next;
    logic bvalid_next;
    logic rvalid_next;

    assign aw_hs = s_axi_awvalid && s_axi_awready;
    assign w_hs = s_axi_wvalid && s_axi_wready;
    assign ar_hs = s_axi_arvalid && s_axi_arready;

    // write fires in the first cycle both halves are held and no response pends
    assign wr_en = aw_full_reg && w_full_reg && !s_axi_bvalid;
    assign wr_idx = awaddr_reg[mcg_pkg::IDX_W+1:2];
    assign rd_en = ar_hs;
    assign rd_idx = s_axi_araddr[mcg_pkg::IDX_W+1:2];

    // next state of holding flags and response valids
    always_comb begin
        aw_full_next = (aw_full_reg || aw_hs) && !wr_en;
        w_full_next = (w_full_reg || w_hs) && !wr_en;
        bvalid_next = wr_en || (s_axi_bvalid && !s_axi_bready);
        rvalid_next = ar_hs || (s_axi_rvalid && !s_axi_rready);
    end

    // write path: address and data may arrive in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            awaddr_reg <= '0;
            wr_data <= 32'h0000_0000;
            wr_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= mcg_pkg::RESP_OKAY;
        end else begin
            aw_full_reg <= aw_full_next;
            w_full_reg <= w_full_next;
            if (aw_hs) begin
                awaddr_reg <= s_axi_awaddr;
            end
            if (w_hs) begin
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
            end
            // ready only while the slot is free and no response pends
            s_axi_awready <= !aw_full_next && !bvalid_next;
            s_axi_wready <= !w_full_next && !bvalid_next;
            s_axi_bvalid <= bvalid_next;
            if (wr_en) begin
                s_axi_bresp <= wr_err ? mcg_pkg::RESP_SLVERR
                                      : mcg_pkg::RESP_OKAY;
            end
        end
    end

    // read path: data captured at the address handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= mcg_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !rvalid_next;
            s_axi_rvalid <= rvalid_next;
            if (ar_hs) begin
                s_axi_rdata <= rd_data;
                s_axi_rresp <= rd_err ? mcg_pkg::RESP_SLVERR
                                      : mcg_pkg::RESP_OKAY;
            end
        end
    end

endmodule // mcg_axil_slave

`default_nettype wire

// ===== mcg_board_model.sv
// board-side pull-ups on the compare and interrupt pins
`default_nettype none

module mcg_board_model (
    // pins as driven by the device
    input wire logic cmp_o,
    input wire logic cmp_oe,
    input wire logic int_o,
    input wire logic int_oe,
    // levels seen on the board
    output logic cmp_lvl,
    output logic int_lvl
);
    timeunit 1ns;
    timeprecision 1ps;
    // released pins rise to the pull-up rather than float
    assign cmp_lvl = cmp_oe ? cmp_o : 1'h1;
    assign int_lvl = int_oe ? int_o : 1'h1;
endmodule // mcg_board_model

`default_nettype wire

// ===== mcg_global_regs.sv
// global configuration, status and position compare register bank
//
// Register access over AXI4-Lite was left to the implementer.
`default_nettype none

module mcg_global_regs #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite register bus
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // motion and driver state
    input wire logic [31:0] motor1_actual_position,
    input wire logic driver1_error,
    input wire logic driver2_error,
    input wire logic pump_undervoltage,
    // configuration outputs and the undervoltage driver disable
    output logic motor1_dir_invert,
    output logic motor2_dir_invert,
    output logic driver_disable,
    // pins, output and enable
    output logic compare_pulse_pin_o,
    output logic compare_pulse_pin_oe,
    output logic int_pin_o,
    output logic int_pin_oe
);

    // ****************************************************************
    // bus front end
    // ****************************************************************
    logic wr_en;
    logic [mcg_pkg::IDX_W-1:0] wr_idx;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_err;
    logic rd_en;
    logic [mcg_pkg::IDX_W-1:0] rd_idx;
    logic [31:0] rd_data;
    logic rd_err;

    mcg_axil_slave #(
        .ADDR_W(ADDR_W)
    ) u_slave (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_idx(wr_idx),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_err(wr_err),
        .rd_en(rd_en),
        .rd_idx(rd_idx),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    // byte-lane merge, shared by every writable register
    function automatic logic [31:0] merge_strb(input logic [31:0] cur,
                                               input logic [31:0] din,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = cur;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = din[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // index decode, shared by read and write paths
    function automatic logic idx_mapped(input logic [mcg_pkg::IDX_W-1:0] idx);
        return idx == mcg_pkg::IDX_CONFIG || idx == mcg_pkg::IDX_STATUS ||
               idx == mcg_pkg::IDX_COMPARE ||
               idx == mcg_pkg::IDX_IRQ_STATUS ||
               idx == mcg_pkg::IDX_IRQ_CLEAR ||
               idx == mcg_pkg::IDX_IRQ_ENABLE;
    endfunction

    // ****************************************************************
    // register storage
    // ****************************************************************
    logic [mcg_pkg::CONFIG_W-1:0] config_reg;
    logic [mcg_pkg::STATUS_W-1:0] status_reg;
    logic [31:0] compare_reg;
    logic [mcg_pkg::IRQ_W-1:0] irq_status_reg;
    logic [mcg_pkg::IRQ_W-1:0] irq_enable_reg;
    logic [31:0] config_merged;
    logic [31:0] cmp_merged;
    logic [31:0] en_merged;
    logic [31:0] clr_merged;
    logic pos_match;
    logic [mcg_pkg::STATUS_W-1:0] status_set;
    logic [mcg_pkg::IRQ_W-1:0] irq_set;

    assign wr_err = !idx_mapped(wr_idx);
    assign rd_err = !idx_mapped(rd_idx);
    assign config_merged = merge_strb({21'h000000, config_reg}, wr_data,
                                      wr_strb);
    assign cmp_merged = merge_strb(compare_reg, wr_data, wr_strb);
    assign en_merged = merge_strb({28'h0000000, irq_enable_reg}, wr_data,
                                  wr_strb);
    assign clr_merged = merge_strb(32'h0000_0000, wr_data, wr_strb);
    assign pos_match = motor1_actual_position == compare_reg;

    // configuration: only defined bits are stored, the rest read zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            config_reg <= mcg_pkg::CONFIG_RESET;
        end else if (wr_en && wr_idx == mcg_pkg::IDX_CONFIG &&
                     !config_reg[mcg_pkg::BIT_LOCK]) begin
            config_reg[mcg_pkg::BIT_POSCMP_EN] <=
                config_merged[mcg_pkg::BIT_POSCMP_EN];
            config_reg[mcg_pkg::BIT_DIR1_INV] <=
                config_merged[mcg_pkg::BIT_DIR1_INV];
            config_reg[mcg_pkg::BIT_DIR2_INV] <=
                config_merged[mcg_pkg::BIT_DIR2_INV];
            // lock only ever sets; nothing but reset releases it
            config_reg[mcg_pkg::BIT_LOCK] <=
                config_merged[mcg_pkg::BIT_LOCK];
        end
    end

    // compare value, write only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            compare_reg <= mcg_pkg::COMPARE_RESET;
        end else if (wr_en && wr_idx == mcg_pkg::IDX_COMPARE) begin
            compare_reg <= cmp_merged;
        end
    end

    // status events; levels keep re-setting their flag while present
    always_comb begin
        status_set = '0;
        status_set[mcg_pkg::BIT_DRV1_ERR] = driver1_error;
        status_set[mcg_pkg::BIT_DRV2_ERR] = driver2_error;
        status_set[mcg_pkg::BIT_PUMP_UV] = pump_undervoltage;
        irq_set = '0;
        irq_set[mcg_pkg::IRQ_DRV1_ERR] = driver1_error;
        irq_set[mcg_pkg::IRQ_DRV2_ERR] = driver2_error;
        irq_set[mcg_pkg::IRQ_PUMP_UV] = pump_undervoltage;
        irq_set[mcg_pkg::IRQ_CMP_HIT] = pos_match && !compare_pulse_pin_o;
    end

    // clear on read; an event in the read cycle survives the clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_reg <= mcg_pkg::STATUS_RESET;
        end else if (rd_en && rd_idx == mcg_pkg::IDX_STATUS) begin
            status_reg <= status_set;
        end else begin
            status_reg <= status_reg | status_set;
        end
    end

    // interrupt status, write-one-to-clear, set wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status_reg <= mcg_pkg::IRQ_RESET;
        end else if (wr_en && wr_idx == mcg_pkg::IDX_IRQ_CLEAR) begin
            irq_status_reg <= (irq_status_reg &
                ~clr_merged[mcg_pkg::IRQ_W-1:0]) | irq_set;
        end else begin
            irq_status_reg <= irq_status_reg | irq_set;
        end
    end

    // interrupt enable mask
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_enable_reg <= mcg_pkg::IRQ_RESET;
        end else if (wr_en && wr_idx == mcg_pkg::IDX_IRQ_ENABLE) begin
            irq_enable_reg <= en_merged[mcg_pkg::IRQ_W-1:0];
        end
    end

    // read mux; write-only registers read zero
    always_comb begin
        rd_data = 32'h0000_0000;
        case (rd_idx)
            mcg_pkg::IDX_CONFIG: rd_data[mcg_pkg::CONFIG_W-1:0] = config_reg;
            mcg_pkg::IDX_STATUS: rd_data[mcg_pkg::STATUS_W-1:0] = status_reg;
            mcg_pkg::IDX_IRQ_STATUS:
                rd_data[mcg_pkg::IRQ_W-1:0] = irq_status_reg;
            mcg_pkg::IDX_IRQ_ENABLE:
                rd_data[mcg_pkg::IRQ_W-1:0] = irq_enable_reg;
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // ****************************************************************
    // outputs, all straight from flip-flops
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            motor1_dir_invert <= 1'b0;
            motor2_dir_invert <= 1'b0;
            driver_disable <= 1'b0;
        end else begin
            motor1_dir_invert <= config_reg[mcg_pkg::BIT_DIR1_INV];
            motor2_dir_invert <= config_reg[mcg_pkg::BIT_DIR2_INV];
            driver_disable <= pump_undervoltage;
        end
    end

    // pins: tristated unless compare-output enable is set; the board
    // must pull them up meanwhile, they float otherwise
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            compare_pulse_pin_o <= 1'b0;
            compare_pulse_pin_oe <= 1'b0;
            int_pin_o <= 1'b0;
            int_pin_oe <= 1'b0;
        end else begin
            compare_pulse_pin_o <= pos_match;
            compare_pulse_pin_oe <= config_reg[mcg_pkg::BIT_POSCMP_EN];
            int_pin_o <= |(irq_status_reg & irq_enable_reg);
            int_pin_oe <= config_reg[mcg_pkg::BIT_POSCMP_EN];
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    property p_pins_tristate;
        @(posedge aclk) disable iff (!aresetn)
        !config_reg[mcg_pkg::BIT_POSCMP_EN] |=>
            !compare_pulse_pin_oe && !int_pin_oe;
    endproperty
    a_pins_tristate: assert property (p_pins_tristate)
        else $error("pins driven while compare output disabled");

    property p_dir1;
        @(posedge aclk) disable iff (!aresetn)
        wr_en && wr_idx == mcg_pkg::IDX_CONFIG && wr_strb[1] &&
        !config_reg[mcg_pkg::BIT_LOCK] |=> ##1
            motor1_dir_invert == $past(wr_data[8], 2);
    endproperty
    a_dir1: assert property (p_dir1)
        else $error("motor 1 direction does not follow config write");

    property p_dir2;
        @(posedge aclk) disable iff (!aresetn)
        wr_en && wr_idx == mcg_pkg::IDX_CONFIG && wr_strb[1] &&
        !config_reg[mcg_pkg::BIT_LOCK] |=> ##1
            motor2_dir_invert == $past(wr_data[9], 2);
    endproperty
    a_dir2: assert property (p_dir2)
        else $error("motor 2 direction does not follow config write");

    property p_lock_ignores;
        @(posedge aclk) disable iff (!aresetn)
        config_reg[mcg_pkg::BIT_LOCK] |=> $stable(config_reg);
    endproperty
    a_lock_ignores: assert property (p_lock_ignores)
        else $error("configuration changed while locked");

    property p_read_clears;
        @(posedge aclk) disable iff (!aresetn)
        rd_en && rd_idx == mcg_pkg::IDX_STATUS && !driver1_error &&
        !driver2_error && !pump_undervoltage |=> status_reg == 4'h0;
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("status not cleared by read");

    property p_drv1_flag;
        @(posedge aclk) disable iff (!aresetn)
        driver1_error |=> status_reg[mcg_pkg::BIT_DRV1_ERR];
    endproperty
    a_drv1_flag: assert property (p_drv1_flag)
        else $error("driver 1 error flag missed");

    property p_drv2_flag;
        @(posedge aclk) disable iff (!aresetn)
        driver2_error |=> status_reg[mcg_pkg::BIT_DRV2_ERR];
    endproperty
    a_drv2_flag: assert property (p_drv2_flag)
        else $error("driver 2 error flag missed");

    property p_pump_uv;
        @(posedge aclk) disable iff (!aresetn)
        pump_undervoltage |=> driver_disable &&
            status_reg[mcg_pkg::BIT_PUMP_UV];
    endproperty
    a_pump_uv: assert property (p_pump_uv)
        else $error("undervoltage did not disable driver");

    property p_compare_pulse;
        @(posedge aclk) disable iff (!aresetn)
        aresetn |=> compare_pulse_pin_o ==
            ($past(motor1_actual_position) == $past(compare_reg));
    endproperty
    a_compare_pulse: assert property (p_compare_pulse)
        else $error("compare pulse does not track position match");

    property p_lock_holds;
        @(posedge aclk) disable iff (!aresetn)
        config_reg[mcg_pkg::BIT_LOCK] |=> config_reg[mcg_pkg::BIT_LOCK];
    endproperty
    a_lock_holds: assert property (p_lock_holds)
        else $error("configuration lock released without reset");

endmodule // mcg_global_regs

`default_nettype wire

// ===== mcg_pkg.sv
// constants for the motor controller global configuration register bank
`default_nettype none

package mcg_pkg;

    // ****************************************************************
    // register word indices (byte address is four times the index)
    // ****************************************************************
    localparam int IDX_W = 6;
    localparam logic [IDX_W-1:0] IDX_CONFIG = 6'h00;
    localparam logic [IDX_W-1:0] IDX_STATUS = 6'h01;
    localparam logic [IDX_W-1:0] IDX_COMPARE = 6'h05;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 6'h10;
    localparam logic [IDX_W-1:0] IDX_IRQ_CLEAR = 6'h11;
    localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 6'h12;

    // ****************************************************************
    // global configuration fields
    // ****************************************************************
    localparam int CONFIG_W = 11;
    localparam int BIT_POSCMP_EN = 0;
    localparam int BIT_DIR1_INV = 8;
    localparam int BIT_DIR2_INV = 9;
    localparam int BIT_LOCK = 10;
    localparam logic [CONFIG_W-1:0] CONFIG_RESET = 11'h000;

    // ****************************************************************
    // global status flags, clear on read
    // ****************************************************************
    localparam int STATUS_W = 4;
    localparam int BIT_RESET_SEEN = 0;
    localparam int BIT_DRV1_ERR = 1;
    localparam int BIT_DRV2_ERR = 2;
    localparam int BIT_PUMP_UV = 3;
    localparam logic [STATUS_W-1:0] STATUS_RESET = 4'h1;

    // ****************************************************************
    // interrupt status / clear / enable layout
    // ****************************************************************
    localparam int IRQ_W = 4;
    localparam int IRQ_DRV1_ERR = 0;
    localparam int IRQ_DRV2_ERR = 1;
    localparam int IRQ_PUMP_UV = 2;
    localparam int IRQ_CMP_HIT = 3;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
    localparam logic [31:0] COMPARE_RESET = 32'h0000_0000;

    // ****************************************************************
    // bus responses
    // ****************************************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : mcg_pkg

`default_nettype wire

// ===== tb_mcg_global_regs.sv
// testbench for the global configuration register bank
`default_nettype none

module tb_mcg_global_regs;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // signals
    // ****************************************
    logic aclk = 1'h0, aresetn = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = 32'h0, pos = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic drv1 = 1'h0, drv2 = 1'h0, uv = 1'h0;
    wire logic awready, wready, bvalid, arready, rvalid, dir1, dir2, dis;
    wire logic cmp_o, cmp_oe, int_o, int_oe, cmp_lvl, int_lvl;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    int err_count = 0, comparisons = 0;

    // 8 ns clock
    initial forever #4 aclk = ~aclk;

    mcg_global_regs #(.ADDR_W(8)) i_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .motor1_actual_position(pos), .driver1_error(drv1),
        .driver2_error(drv2), .pump_undervoltage(uv),
        .motor1_dir_invert(dir1), .motor2_dir_invert(dir2),
        .driver_disable(dis), .compare_pulse_pin_o(cmp_o),
        .compare_pulse_pin_oe(cmp_oe), .int_pin_o(int_o),
        .int_pin_oe(int_oe));

    mcg_board_model i_board (.cmp_o(cmp_o), .cmp_oe(cmp_oe), .int_o(int_o),
        .int_oe(int_oe), .cmp_lvl(cmp_lvl), .int_lvl(int_lvl));

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // bus write; bready stays up until the response is seen
    task automatic wr(input logic [5:0] i, input logic [31:0] d,
                      input logic [1:0] er = mcg_pkg::RESP_OKAY,
                      input logic [3:0] s = 4'hF);
        @(posedge aclk);
        awaddr <= {i, 2'h0};
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        forever begin
            @(posedge aclk);
            if (awready && awvalid) awvalid <= 1'h0;
            if (wready && wvalid) wvalid <= 1'h0;
            if (bvalid) break;
        end
        bready <= 1'h0;
        chk("bvalid", 32'h1, {31'h0, bvalid});
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask

    // bus read, data taken at the handshake edge
    task automatic rd(input logic [5:0] i, input logic [31:0] e,
                      input logic [1:0] er = mcg_pkg::RESP_OKAY);
        @(posedge aclk);
        araddr <= {i, 2'h0};
        arvalid <= 1'h1;
        rready <= 1'h1;
        forever begin
            @(posedge aclk);
            if (arready && arvalid) arvalid <= 1'h0;
            if (rvalid) break;
        end
        rready <= 1'h0;
        chk("rvalid", 32'h1, {31'h0, rvalid});
        chk("rdata", e, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        rd(mcg_pkg::IDX_STATUS, 32'h1);
        rd(mcg_pkg::IDX_STATUS, 32'h0);
        rd(mcg_pkg::IDX_CONFIG, 32'h0);
        chk("cmp_oe", 32'h0, {31'h0, cmp_oe});
        chk("int_lvl", 32'h1, {31'h0, int_lvl});
    endtask

    // byte strobe 0 alone must leave the direction bits alone
    task automatic t_config;
        wr(mcg_pkg::IDX_CONFIG, 32'h301);
        tick(2);
        chk("dir1", 32'h1, {31'h0, dir1});
        chk("dir2", 32'h1, {31'h0, dir2});
        chk("int_oe", 32'h1, {31'h0, int_oe});
        rd(mcg_pkg::IDX_CONFIG, 32'h301);
        wr(mcg_pkg::IDX_CONFIG, 32'h0, mcg_pkg::RESP_OKAY, 4'h1);
        rd(mcg_pkg::IDX_CONFIG, 32'h300);
        wr(mcg_pkg::IDX_CONFIG, 32'h200);
        tick(2);
        chk("dir1", 32'h0, {31'h0, dir1});
        chk("cmp_oe", 32'h0, {31'h0, cmp_oe});
    endtask

    // lock, then a mid-run reset must lift it
    task automatic t_lock;
        wr(mcg_pkg::IDX_CONFIG, 32'h401);
        wr(mcg_pkg::IDX_CONFIG, 32'h300);
        rd(mcg_pkg::IDX_CONFIG, 32'h401);
        @(posedge aclk) aresetn <= 1'h0;
        tick(2);
        aresetn <= 1'h1;
        rd(mcg_pkg::IDX_CONFIG, 32'h0);
        rd(mcg_pkg::IDX_STATUS, 32'h1);
    endtask

    // two-cycle events must stick until the status read
    task automatic t_status;
        for (int k = 0; k < 3; k++) begin
            @(posedge aclk) {uv, drv2, drv1} <= 3'h1 << k;
            tick(2);
            if (k == 2) chk("dis", 32'h1, {31'h0, dis});
            {uv, drv2, drv1} <= 3'h0;
            tick(3);
            rd(mcg_pkg::IDX_STATUS, 32'h2 << k);
        end
        chk("dis", 32'h0, {31'h0, dis});
        rd(mcg_pkg::IDX_STATUS, 32'h0);
    endtask

    task automatic t_compare;
        wr(mcg_pkg::IDX_CONFIG, 32'h1);
        wr(mcg_pkg::IDX_COMPARE, 32'h1234_5678);
        pos <= 32'h1234_5678;
        tick(3);
        chk("cmp_lvl", 32'h1, {31'h0, cmp_lvl});
        pos <= 32'h1234_5679;
        tick(3);
        chk("cmp_lvl", 32'h0, {31'h0, cmp_lvl});
        rd(mcg_pkg::IDX_COMPARE, 32'h0);
    endtask

    // interrupt raised, cleared and masked; unmapped place refused
    task automatic t_irq;
        // driver, pump and compare-hit events since the last reset
        rd(mcg_pkg::IDX_IRQ_STATUS, 32'hF);
        wr(mcg_pkg::IDX_IRQ_CLEAR, 32'hF);
        wr(mcg_pkg::IDX_IRQ_ENABLE, 32'h1);
        @(posedge aclk) drv1 <= 1'h1;
        @(posedge aclk) drv1 <= 1'h0;
        tick(3);
        chk("int_lvl", 32'h1, {31'h0, int_lvl});
        rd(mcg_pkg::IDX_IRQ_STATUS, 32'h1);
        wr(mcg_pkg::IDX_IRQ_CLEAR, 32'h1);
        tick(3);
        chk("int_lvl", 32'h0, {31'h0, int_lvl});
        wr(mcg_pkg::IDX_IRQ_ENABLE, 32'h0);
        @(posedge aclk) drv2 <= 1'h1;
        @(posedge aclk) drv2 <= 1'h0;
        tick(3);
        chk("int_lvl", 32'h0, {31'h0, int_lvl});
        rd(mcg_pkg::IDX_IRQ_STATUS, 32'h2);
        wr(6'h3F, 32'h1, mcg_pkg::RESP_SLVERR);
        rd(6'h3F, 32'h0, mcg_pkg::RESP_SLVERR);
    endtask

    // counts, verdict and end of run
    task automatic results;
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // a hang counts as a mismatch
    initial begin
        tick(20000);
        err_count++;
        results;
    end

    // main sequence after a six-cycle reset
    initial begin
        tick(6);
        aresetn <= 1'h1;
        t_reset;
        t_config;
        t_lock;
        t_status;
        t_compare;
        t_irq;
        results;
    end
endmodule // tb_mcg_global_regs

`default_nettype wire
